// >>> verilog/cpr_regs.svh
// cpr_regs.svh: register offsets, field positions, reset values and timing counts for the
// host-side select / power-down / reset controller.
// assumes a 100 MHz sys_clk and a classic Wishbone slave port with 32-bit data.
`ifndef CPR_REGS_SVH
`define CPR_REGS_SVH

// byte offsets on the Wishbone port
`define CPR_OFF_CTRL 8'h00
`define CPR_OFF_CMD 8'h04
`define CPR_OFF_STAT 8'h08
`define CPR_OFF_MASK 8'h0C

// control register fields
`define CPR_CTRL_LOW_VOLT 0
`define CPR_CTRL_RST_HIGH 1
`define CPR_CTRL_PIN_EXTRA 2
`define CPR_CTRL_LATCHED 3
`define CPR_CTRL_STB_LOW 4
`define CPR_CTRL_PWR_DOWN 5
`define CPR_CTRL_EXTRA_VAL 6
`define CPR_CTRL_RESET 7'h00

// command register bits, write one to act
`define CPR_CMD_RESET 0
`define CPR_CMD_STROBE 1

// status register bits; bits 4..6 are sticky, write one to clear
`define CPR_ST_READY 0
`define CPR_ST_IN_RST 1
`define CPR_ST_RECOVER 2
`define CPR_ST_PWR_DOWN 3
`define CPR_ST_REFUSED 4
`define CPR_ST_SEL_ERR 5
`define CPR_ST_REGS_ZERO 6
`define CPR_ST_STB_BUSY 7

// mask register: [10:0] pins used as selects, [23:16] port B open-drain
`define CPR_MASK_CS_LSB 0
`define CPR_MASK_OD_LSB 16
`define CPR_MASK_RESET 32'h0000_0000

// timing, figures in ns, counts derived with rounding up
`define CPR_CLK_NS 10
`define CPR_RST_STD_NS 100
`define CPR_RST_LV_NS 500
`define CPR_RECOV_LV_NS 500
`define CPR_STROBE_NS 50
`define CPR_CYC(ns) (((ns) + `CPR_CLK_NS - 1) / `CPR_CLK_NS)
`define CPR_RST_STD_CYC `CPR_CYC(`CPR_RST_STD_NS)
`define CPR_RST_LV_CYC `CPR_CYC(`CPR_RST_LV_NS)
`define CPR_RECOV_LV_CYC `CPR_CYC(`CPR_RECOV_LV_NS)
`define CPR_STROBE_CYC `CPR_CYC(`CPR_STROBE_NS)
`define CPR_SETTLE_CYC 2

`endif

// >>> verilog/cpr_pkg.sv
// cpr_pkg: types shared by the select / power-down / reset controller.
// assumes cpr_regs.svh for all numbers.
package cpr_pkg;

    // reset sequence of the attached device and the host processor
    typedef enum logic [1:0] {
        RS_ASSERT = 2'b00,
        RS_RECOVER = 2'b01,
        RS_HOSTREL = 2'b10,
        RS_READY = 2'b11
    } cpr_rst_e;

    // control fields as software sets them
    typedef struct packed {
        logic extra_val;
        logic pwr_down;
        logic stb_low;
        logic latched;
        logic pin_extra;
        logic rst_high;
        logic low_volt;
    } cpr_ctrl_s;

    // pins toward the device
    typedef struct packed {
        logic dev_rst;
        logic sel_pin;
        logic strobe;
    } cpr_pins_s;

    typedef logic [7:0] cpr_cnt_t;

endpackage : cpr_pkg

// >>> verilog/cpr_timer.sv
// cpr_timer: loadable down-counter giving one expiry pulse.
// assumes load and value come from the same clock domain.
`timescale 1ns/100ps
module cpr_timer (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic load,
    input wire cpr_pkg::cpr_cnt_t load_val,
    output logic busy,
    output logic expired
);
    cpr_pkg::cpr_cnt_t count_r;

    // a load restarts the count even while running
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_r <= 8'h00;
        end else if (load) begin
            count_r <= load_val;
        end else if (count_r != 8'h00) begin
            count_r <= count_r - 8'h01;
        end
    end

    assign busy = (count_r != 8'h00);
    assign expired = !load && (count_r == 8'h01);
endmodule : cpr_timer

// >>> verilog/cpr_host.sv
// cpr_host: host-side controller that drives the select/extra-input pin, the address latch
// strobe and the reset pin of an attached programmable peripheral, and holds the host
// processor in reset until the peripheral is usable.
// assumes device select outputs are sampled on sys_clk and software uses classic Wishbone.
`timescale 1ns/100ps
`include "cpr_regs.svh"

// How it works
// - standard parts: reset at least 100 ns
// - low-voltage parts: reset at least 500 ns
// - low-voltage parts: reset always low-true
// - device ready before host's first access
// - reset lines driven actively, never RC ramps
module cpr_host (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] port_b_selects,
    input wire logic [2:0] port_c_selects,
    output logic select_or_extra_input_pin,
    output logic addr_latch_strobe,
    output logic dev_rst_pin,
    output logic host_rst_n,
    output logic access_ok
);
    cpr_pkg::cpr_ctrl_s ctrl_r;
    logic [10:0] cs_en_r;
    logic [7:0] od_mask_r;
    cpr_pkg::cpr_rst_e rst_state_r;
    cpr_pkg::cpr_rst_e rst_state_nxt;
    cpr_pkg::cpr_pins_s pins_r;
    cpr_pkg::cpr_pins_s pins_nxt;
    logic ack_r;
    logic [31:0] rdat_r;
    logic wr_en;
    logic rd_req;
    logic cmd_reset;
    logic cmd_strobe;
    logic rst_load_r;
    cpr_pkg::cpr_cnt_t rst_load_val;
    logic rst_busy;
    logic rst_expired;
    logic stb_load;
    logic stb_busy;
    logic extra_hold_r;
    logic pd_active;
    logic [1:0] pd_settle_r;
    logic chk_pd;
    logic chk_rst;
    logic [10:0] cs_seen;
    logic [10:0] cs_must_high;
    logic sel_err_evt;
    logic refused_evt;
    logic refused_r;
    logic sel_err_r;
    logic regs_zero_r;
    logic access_ok_r;
    logic host_rst_n_r;

    // bus decode: write lands on the edge that also sees ack high
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
    assign rd_req = wb_cyc_i && wb_stb_i && !ack_r;
    assign cmd_reset = wr_en && (wb_adr_i == `CPR_OFF_CMD) && wb_sel_i[0]
        && wb_dat_i[`CPR_CMD_RESET];
    assign cmd_strobe = wr_en && (wb_adr_i == `CPR_OFF_CMD) && wb_sel_i[0]
        && wb_dat_i[`CPR_CMD_STROBE];

    // one-wait-state ack; dropped in the cycle after it was given
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
        end
    end

    // read mux; unmapped offsets read zero and are still acked
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdat_r <= 32'h0000_0000;
        end else if (rd_req) begin
            unique case (wb_adr_i)
                `CPR_OFF_CTRL: rdat_r <= {25'h0, ctrl_r};
                `CPR_OFF_STAT: begin
                    rdat_r <= 32'h0000_0000;
                    rdat_r[`CPR_ST_READY] <= (rst_state_r == cpr_pkg::RS_READY);
                    rdat_r[`CPR_ST_IN_RST] <= (rst_state_r == cpr_pkg::RS_ASSERT);
                    rdat_r[`CPR_ST_RECOVER] <= (rst_state_r == cpr_pkg::RS_RECOVER);
                    rdat_r[`CPR_ST_PWR_DOWN] <= pd_active;
                    rdat_r[`CPR_ST_REFUSED] <= refused_r;
                    rdat_r[`CPR_ST_SEL_ERR] <= sel_err_r;
                    rdat_r[`CPR_ST_REGS_ZERO] <= regs_zero_r;
                    rdat_r[`CPR_ST_STB_BUSY] <= stb_busy;
                end
                `CPR_OFF_MASK: rdat_r <= {8'h00, od_mask_r, 5'h00, cs_en_r};
                default: rdat_r <= 32'h0000_0000;
            endcase
        end
    end

    // control and mask registers, byte lanes honoured
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= `CPR_CTRL_RESET;
            cs_en_r <= 11'h000;
            od_mask_r <= 8'h00;
        end else if (wr_en) begin
            if (wb_adr_i == `CPR_OFF_CTRL && wb_sel_i[0]) begin
                ctrl_r <= cpr_pkg::cpr_ctrl_s'(wb_dat_i[6:0]);
            end
            if (wb_adr_i == `CPR_OFF_MASK) begin
                if (wb_sel_i[0]) begin
                    cs_en_r[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    cs_en_r[10:8] <= wb_dat_i[10:8];
                end
                if (wb_sel_i[2]) begin
                    od_mask_r <= wb_dat_i[23:16];
                end
            end
        end
    end

    // reset sequence: a command restarts it from any state at once
    always_comb begin
        rst_state_nxt = rst_state_r;
        unique case (rst_state_r)
            cpr_pkg::RS_ASSERT: begin
                if (rst_expired) begin
                    rst_state_nxt = ctrl_r.low_volt ? cpr_pkg::RS_RECOVER
                        : cpr_pkg::RS_HOSTREL;
                end
            end
            cpr_pkg::RS_RECOVER: begin
                if (rst_expired) begin
                    rst_state_nxt = cpr_pkg::RS_HOSTREL;
                end
            end
            cpr_pkg::RS_HOSTREL: rst_state_nxt = cpr_pkg::RS_READY;
            cpr_pkg::RS_READY: rst_state_nxt = cpr_pkg::RS_READY;
        endcase
        if (cmd_reset) begin
            rst_state_nxt = cpr_pkg::RS_ASSERT;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_state_r <= cpr_pkg::RS_ASSERT;
        end else begin
            rst_state_r <= rst_state_nxt;
        end
    end

    // timer load one cycle after each reset command and each entry to RS_RECOVER; set at power-on so the first pulse is timed
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_load_r <= 1'b1;
        end else begin
            rst_load_r <= cmd_reset || (rst_state_nxt == cpr_pkg::RS_RECOVER
                && rst_state_r != cpr_pkg::RS_RECOVER);
        end
    end

    // low-voltage parts get the longer pulse and a separate recovery wait
    always_comb begin
        if (rst_state_r == cpr_pkg::RS_RECOVER) begin
            rst_load_val = 8'(`CPR_RECOV_LV_CYC);
        end else if (ctrl_r.low_volt) begin
            rst_load_val = 8'(`CPR_RST_LV_CYC);
        end else begin
            rst_load_val = 8'(`CPR_RST_STD_CYC);
        end
    end

    cpr_timer u_rst_timer (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .load(rst_load_r),
        .load_val(rst_load_val),
        .busy(rst_busy),
        .expired(rst_expired)
    );

    // strobe only makes sense for a latched extra input
    assign stb_load = cmd_strobe && ctrl_r.pin_extra && ctrl_r.latched && !stb_busy;

    cpr_timer u_stb_timer (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .load(stb_load),
        .load_val(8'(`CPR_STROBE_CYC)),
        .busy(stb_busy),
        .expired()
    );

    // extra input value is frozen while a strobe is out so the trailing edge sees it steady
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            extra_hold_r <= 1'b0;
        end else if (!stb_busy && !stb_load) begin
            extra_hold_r <= ctrl_r.extra_val;
        end
    end

    // a power-down request in extra-input mode is ignored, never driven to the pin
    assign pd_active = !ctrl_r.pin_extra && ctrl_r.pwr_down;

    // pin values; reset polarity fixed low-true on low-voltage parts
    always_comb begin
        pins_nxt.dev_rst = (rst_state_r == cpr_pkg::RS_ASSERT);
        if (ctrl_r.low_volt || !ctrl_r.rst_high) begin
            pins_nxt.dev_rst = !pins_nxt.dev_rst;
        end
        if (ctrl_r.pin_extra) begin
            pins_nxt.sel_pin = extra_hold_r;
        end else begin
            pins_nxt.sel_pin = pd_active;
        end
        // strobe stands for the whole count, so its width is exactly the timer load
        pins_nxt.strobe = stb_busy ^ ctrl_r.stb_low;
    end

    // all device pins come from flops and are always driven, never left to ramp
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pins_r <= 3'b000;
        end else begin
            pins_r <= pins_nxt;
        end
    end

    // host held in reset until the device is usable; no access while powered down
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            host_rst_n_r <= 1'b0;
            access_ok_r <= 1'b0;
        end else begin
            // host waits until the device pin has already been released for a cycle
            host_rst_n_r <= (rst_state_r == cpr_pkg::RS_READY)
                && (rst_state_nxt == cpr_pkg::RS_READY);
            access_ok_r <= (rst_state_r == cpr_pkg::RS_READY)
                && (rst_state_nxt == cpr_pkg::RS_READY) && !pd_active;
        end
    end

    // pins respond without a clock but are sampled here; wait a little before judging them
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pd_settle_r <= 2'b00;
        end else if (!pd_active || !pins_r.sel_pin) begin
            pd_settle_r <= 2'b00;
        end else if (pd_settle_r != 2'(`CPR_SETTLE_CYC)) begin
            pd_settle_r <= pd_settle_r + 2'b01;
        end
    end

    // open-drain port B selects float and are skipped; every other select enabled in the mask must read high
    assign cs_seen = {port_c_selects, port_b_selects};
    assign cs_must_high = cs_en_r & ~{3'b000, od_mask_r};
    assign chk_pd = (pd_settle_r == 2'(`CPR_SETTLE_CYC));
    assign chk_rst = !ctrl_r.low_volt && (rst_state_r == cpr_pkg::RS_ASSERT)
        && (rst_load_r == 1'b0) && rst_busy;
    assign sel_err_evt = (chk_pd || chk_rst) && ((cs_seen & cs_must_high) != cs_must_high);
    assign refused_evt = (ctrl_r.pin_extra && ctrl_r.pwr_down)
        || (cmd_strobe && !stb_load);

    // sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            refused_r <= 1'b0;
            sel_err_r <= 1'b0;
        end else begin
            if (refused_evt) begin
                refused_r <= 1'b1;
            end else if (wr_en && wb_adr_i == `CPR_OFF_STAT && wb_sel_i[0]
                && wb_dat_i[`CPR_ST_REFUSED]) begin
                refused_r <= 1'b0;
            end
            if (sel_err_evt) begin
                sel_err_r <= 1'b1;
            end else if (wr_en && wb_adr_i == `CPR_OFF_STAT && wb_sel_i[0]
                && wb_dat_i[`CPR_ST_SEL_ERR]) begin
                sel_err_r <= 1'b0;
            end
        end
    end

    // device registers known zero after each reset; power-down does not disturb this
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            regs_zero_r <= 1'b0;
        end else if (rst_state_r == cpr_pkg::RS_ASSERT) begin
            regs_zero_r <= 1'b1;
        end else if (wr_en && wb_adr_i == `CPR_OFF_STAT && wb_sel_i[0]
            && wb_dat_i[`CPR_ST_REGS_ZERO]) begin
            regs_zero_r <= 1'b0;
        end
    end

    // outputs straight from flops
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
    assign dev_rst_pin = pins_r.dev_rst;
    assign select_or_extra_input_pin = pins_r.sel_pin;
    assign addr_latch_strobe = pins_r.strobe;
    assign host_rst_n = host_rst_n_r;
    assign access_ok = access_ok_r;
endmodule : cpr_host

// >>> dv/cpr_host_properties.sv
// cpr_host_properties: timing checks on the controller ports.
// assumes a bind to cpr_host and an active-high address strobe.
`timescale 1ns/100ps
module cpr_host_properties (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic select_or_extra_input_pin,
    input wire logic addr_latch_strobe,
    input wire logic dev_rst_pin,
    input wire logic host_rst_n,
    input wire logic access_ok
);
    // one domain, so clock and reset are stated once
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic idle_lvl_r;
    // level of the device reset pin while the host runs; reset value is the low-true idle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            idle_lvl_r <= 1'b1;
        end else if (host_rst_n) begin
            idle_lvl_r <= dev_rst_pin;
        end
    end
    // bus answer and unmapped reads
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > 8'h0C
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    // polarity-free: the pin must not move for eight cycles, starting two cycles after the host is held
    a_rst_pulse_min: assert property ($fell(host_rst_n) |-> ##2 $stable(dev_rst_pin)[*8])
        else $error("device reset pulse short");
    a_host_after_dev: assert property ($rose(host_rst_n) |-> $past(dev_rst_pin) == idle_lvl_r)
        else $error("host released with device");
    a_access_needs_host: assert property (access_ok |-> host_rst_n)
        else $error("access while host held");
    a_strobe_width: assert property ($rose(addr_latch_strobe)
        |-> addr_latch_strobe[*5] ##1 !addr_latch_strobe)
        else $error("strobe width wrong");
    a_pin_frozen: assert property (addr_latch_strobe |-> $stable(select_or_extra_input_pin))
        else $error("extra input moved under strobe");
endmodule : cpr_host_properties

// >>> dv/cpr_dev_model.sv
// cpr_dev_model: behavioural peripheral answering the pins with select outputs.
// assumes an active-high strobe and pull-ups on open-drain selects.
`timescale 1ns/100ps
module cpr_dev_model (
    input wire cpr_pkg::cpr_ctrl_s cfg,
    input wire logic bad_sel,
    input wire logic sel_pin,
    input wire logic strobe,
    input wire logic dev_rst,
    output logic [7:0] port_b_selects,
    output logic [2:0] port_c_selects
);
    logic in_rst;
    logic pd;
    logic lat_q;
    logic term;
    // low-volt parts are low-true whatever the host prefers; no clock involved
    assign in_rst = (cfg.rst_high && !cfg.low_volt) ? dev_rst : !dev_rst;
    assign pd = sel_pin && !cfg.pin_extra;
    // trailing strobe edge latches the extra input, reset clears it
    always @(negedge strobe or posedge in_rst) begin
        if (in_rst) begin
            lat_q <= 1'b0;
        end else begin
            lat_q <= sel_pin;
        end
    end
    assign term = cfg.latched ? lat_q : sel_pin;
    // selects idle high in reset and power-down; open drain floats up to the pull-up
    always_comb begin
        port_b_selects = {7'h7F, !term};
        port_c_selects = 3'h7;
        if (in_rst || pd) begin
            port_b_selects = 8'hFF;
        end
        if (pd && bad_sel) begin
            port_b_selects = 8'h00; // only when a scenario asks for a faulty part
        end
    end
endmodule : cpr_dev_model

// >>> dv/cpr_host_tb_top.sv
// cpr_host_tb_top: drives cpr_host over Wishbone with the peripheral model on its pins.
// assumes cpr_regs.svh, cpr_pkg, the model and the checker compiled first.
`timescale 1ns/100ps
`include "cpr_regs.svh"
module cpr_host_tb_top;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic bad_sel = 1'b0;
    cpr_pkg::cpr_ctrl_s cfg = 7'h00;
    logic [31:0] rdat;
    logic ack;
    logic [7:0] pb;
    logic [2:0] pc;
    logic pin;
    logic strobe;
    logic dev_rst;
    logic host_rst_n;
    logic access_ok;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int n;
    int m;
    logic [31:0] q;
    cpr_host cpr_host_inst (
        .sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .port_b_selects(pb), .port_c_selects(pc), .select_or_extra_input_pin(pin),
        .addr_latch_strobe(strobe), .dev_rst_pin(dev_rst), .host_rst_n(host_rst_n),
        .access_ok(access_ok)
    );
    cpr_dev_model cpr_dev_model_inst (
        .cfg(cfg), .bad_sel(bad_sel), .sel_pin(pin), .strobe(strobe), .dev_rst(dev_rst),
        .port_b_selects(pb), .port_c_selects(pc)
    );
    // 100 MHz
    always #5 sys_clk = ~sys_clk;
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    // hang guard; the longest wait is a low-volt reset of some 104 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s: expected %h, seen %h", nm, exp, got);
        end
    endtask : check
    // one classic cycle; ack is read at the rising edge, before that edge's updates land
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        @(posedge sys_clk);
        while (ack !== 1'b1 && t < 50) begin
            @(posedge sys_clk);
            t++;
        end
        check("ack", 32'h1, {31'h0, ack});
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (w && a == `CPR_OFF_CTRL) cfg <= d[6:0];
    endtask : wb
    function automatic logic pick(input int w);
        case (w)
            0: return dev_rst;
            1: return strobe;
            2: return host_rst_n;
            default: return access_ok;
        endcase
    endfunction : pick
    // counts edges while a pin keeps one level, bounded
    task automatic hold(input int w, input logic lvl, output int c);
        c = 0;
        #1;
        while (pick(w) === lvl && c < 2000) begin
            @(posedge sys_clk);
            #1;
            c++;
        end
    endtask : hold
    initial begin
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        hold(3, 1'b0, n);
        check("access_ok", 32'h1, {31'h0, access_ok});
        wb(1'b0, `CPR_OFF_CTRL, 32'h0);
        check("ctrl reset", `CPR_CTRL_RESET, q);
        wb(1'b0, `CPR_OFF_MASK, 32'h0);
        check("mask reset", `CPR_MASK_RESET, q);
        wb(1'b1, 8'h20, 32'hFFFF_FFFF);
        wb(1'b0, 8'h20, 32'h0);
        check("unmapped", 32'h0, q);
        // flavours: standard low-true, standard high-true, low-volt with high-true asked
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, `CPR_OFF_CTRL, (i == 2) ? 32'h3 : ((i == 1) ? 32'h2 : 32'h0));
            wb(1'b1, `CPR_OFF_CMD, 32'h1);
            hold(0, i != 1, n);
            hold(0, i == 1, n);
            check("rst width", 32'h1, n >= ((i == 2) ? `CPR_RST_LV_CYC : `CPR_RST_STD_CYC));
            hold(2, 1'b0, m);
            check("host delay", 32'h1, (i == 2) ? m >= `CPR_RECOV_LV_CYC : m <= 3);
            hold(3, 1'b0, m);
        end
        wb(1'b1, `CPR_OFF_CTRL, 32'h0);
        wb(1'b1, `CPR_OFF_MASK, 32'h1);
        wb(1'b1, `CPR_OFF_CTRL, 32'h20);
        repeat (2) @(posedge sys_clk);
        #1;
        check("pd pin", 32'h1, {31'h0, pin});
        check("pd access", 32'h0, {31'h0, access_ok});
        wb(1'b0, `CPR_OFF_STAT, 32'h0);
        check("pd status", 32'h1, {31'h0, q[`CPR_ST_PWR_DOWN]});
        check("sel ok", 32'h0, {31'h0, q[`CPR_ST_SEL_ERR]});
        bad_sel <= 1'b1;
        repeat (4) @(posedge sys_clk);
        wb(1'b0, `CPR_OFF_STAT, 32'h0);
        check("sel err", 32'h1, {31'h0, q[`CPR_ST_SEL_ERR]});
        bad_sel <= 1'b0;
        wb(1'b1, `CPR_OFF_STAT, 32'h70);
        wb(1'b1, `CPR_OFF_CTRL, 32'h0);
        repeat (3) @(posedge sys_clk);
        #1;
        check("run pin", 32'h0, {31'h0, pin});
        check("run access", 32'h1, {31'h0, access_ok});
        wb(1'b1, `CPR_OFF_CTRL, 32'h64);
        repeat (3) @(posedge sys_clk);
        #1;
        check("extra pin", 32'h1, {31'h0, pin});
        check("extra access", 32'h1, {31'h0, access_ok});
        wb(1'b0, `CPR_OFF_STAT, 32'h0);
        check("pd refused", 32'h1, {31'h0, q[`CPR_ST_REFUSED]});
        wb(1'b1, `CPR_OFF_CTRL, 32'h0C);
        wb(1'b1, `CPR_OFF_STAT, 32'h70);
        wb(1'b1, `CPR_OFF_CMD, 32'h2);
        hold(1, 1'b0, n);
        hold(1, 1'b1, n);
        check("strobe width", `CPR_STROBE_CYC, n);
        wb(1'b0, `CPR_OFF_STAT, 32'h0);
        check("strobe taken", 32'h0, {31'h0, q[`CPR_ST_REFUSED]});
        wb(1'b1, `CPR_OFF_CTRL, 32'h0);
        wb(1'b1, `CPR_OFF_CMD, 32'h2);
        wb(1'b0, `CPR_OFF_STAT, 32'h0);
        check("strobe refused", 32'h1, {31'h0, q[`CPR_ST_REFUSED]});
        give_verdict();
    end
endmodule : cpr_host_tb_top
bind cpr_host cpr_host_properties cpr_host_properties_inst (
    .sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .select_or_extra_input_pin(select_or_extra_input_pin),
    .addr_latch_strobe(addr_latch_strobe), .dev_rst_pin(dev_rst_pin),
    .host_rst_n(host_rst_n), .access_ok(access_ok)
);
